// file: rtl/rsc_pkg.sv
// reset sequencing control: shared constants, register map, state codes
// assumes a single 125 MHz clock and a 32-bit AXI4-Lite register port
package rsc_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_WDCTL  = 8'h00;
  localparam logic [7:0] ADDR_CLKSEL = 8'h04;
  localparam logic [7:0] ADDR_STAT   = 8'h08;
  localparam logic [7:0] ADDR_CLR    = 8'h0C;
  localparam logic [7:0] ADDR_IEN    = 8'h10;
  localparam logic [7:0] ADDR_STATE  = 8'h14;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_WDT_CAUSE = 0;
  localparam int BIT_USB_MODE  = 1;
  localparam int BIT_UART_SEL  = 0;
  localparam int BIT_HSU_SEL   = 1;
  localparam int EV_EXT        = 0;
  localparam int EV_WDT        = 1;
  localparam int EV_FETCH      = 2;
  localparam int EV_W          = 3;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [1:0]      CLKSEL_RST = 2'h0;
  localparam logic [EV_W-1:0] IEN_RST    = 3'h0;
  localparam logic [19:0]     RESET_VEC  = 20'hFFFF0;

  // ---------------------------------------------------------------
  // timing, in clocks
  // ---------------------------------------------------------------
  localparam int WDT_HOLD_CYC  = 65536;
  // 4.5 and 6.5 clocks round up to whole cycles
  localparam int BUS_START_CYC = 5;
  localparam int FETCH_CYC     = 7;
  localparam int CLR_HOLD_CYC  = 2;
  localparam int CNT_W         = 17;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ST_RUN      = 4'h1,
    ST_EXT_HOLD = 4'h2,
    ST_EXT_EXIT = 4'h4,
    ST_WDT_HOLD = 4'h8
  } rsc_state_t;

endpackage : rsc_pkg

// file: rtl/rsc_top.sv
// reset sequencing control: reset arbitration, exit timing, straps,
// serial clock source selects and AXI4-Lite registers
// assumes external_clear_n is asynchronous; all else synchronous to clock
//
// Overview of operation
// - an external clear during a watchdog reset aborts it and is handled as external.
// - an external clear leaves the watchdog cause flag cleared and drives system clear.
// - a watchdog-only reset holds the device for 2^16 clocks from the timeout.
// - after an external clear the first bus cycle starts 4.5 (5) clocks after release.
// - instruction fetch begins 6.5 (7) clocks after the external clear releases.
// - system clear out is high in every reset; after an external release it drops three clocks before core hold.
// - system clear out is active high and stays high two clocks after external release; it drops with core hold at watchdog release.
// - the alternate serial clock may replace the cpu clock for either uart.
// - the two uart source selects are independent and may match.
// - the usb strap sampled low at reset release maps four pins to the usb phy.
// - an external clear stops the core within three clocks, after the synchroniser; on release it starts at FFFF0h.
// - the external clear input is synchronised before use.
`timescale 1ns/1ns
module rsc_top #(
  parameter int WDT_CYCLES = rsc_pkg::WDT_HOLD_CYC
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        external_clear_n,
  input  wire logic        watchdog_timeout,
  input  wire logic        usb_phy_strap,
  input  wire logic        usb_tx_plus_core,
  input  wire logic        usb_tx_minus_core,
  input  wire logic        usb_phy_oe_core,
  input  wire logic        usb_phy_receive_in,
  output logic             system_clear_out,
  output logic             core_hold,
  output logic             bus_start,
  output logic             fetch_start,
  output logic [19:0]      reset_vector,
  output logic             uart_alt_src_sel,
  output logic             hsuart_alt_src_sel,
  output logic             usb_tx_plus_out,
  output logic             usb_tx_plus_oe_n,
  output logic             usb_tx_minus_out,
  output logic             usb_tx_minus_oe_n,
  output logic             usb_phy_output_enable,
  output logic             usb_phy_output_enable_oe_n,
  output logic             usb_receive_core,
  output logic             irq
);
  import rsc_pkg::*;

  // ---------------------------------------------------------------
  // external clear synchroniser
  // ---------------------------------------------------------------
  logic ext_meta_q;
  logic ext_sync_q;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
    end else begin
      ext_meta_q <= external_clear_n;
      ext_sync_q <= ext_meta_q;
    end
  end

  wire ext_active = !ext_sync_q;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  rsc_state_t             state_q;
  logic [CNT_W-1:0]       cnt_q;
  logic                   ext_ev;
  logic                   wdt_ev;
  logic                   fetch_ev;

  function automatic logic cnt_at(input logic [CNT_W-1:0] c,
                                  input int n);
    cnt_at = (c == CNT_W'(n - 1));
  endfunction : cnt_at

  wire wdt_done  = (state_q == ST_WDT_HOLD) && cnt_at(cnt_q, WDT_CYCLES);
  wire exit_done = (state_q == ST_EXT_EXIT) && cnt_at(cnt_q, FETCH_CYC);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_q <= ST_EXT_HOLD;
      cnt_q   <= '0;
    end else if (ext_active) begin
      // external clear wins from any state, watchdog hold included
      state_q <= ST_EXT_HOLD;
      cnt_q   <= '0;
    end else begin
      unique case (state_q)
        ST_RUN: begin
          if (watchdog_timeout) begin
            state_q <= ST_WDT_HOLD;
            cnt_q   <= '0;
          end
        end
        ST_EXT_HOLD: begin
          state_q <= ST_EXT_EXIT;
          cnt_q   <= '0;
        end
        ST_EXT_EXIT: begin
          cnt_q <= cnt_q + CNT_W'(1);
          if (exit_done) state_q <= ST_RUN;
        end
        ST_WDT_HOLD: begin
          cnt_q <= cnt_q + CNT_W'(1);
          if (wdt_done) state_q <= ST_RUN;
        end
      endcase
    end
  end

  assign ext_ev   = ext_active && (state_q != ST_EXT_HOLD);
  assign wdt_ev   = !ext_active && (state_q == ST_RUN) && watchdog_timeout;
  assign fetch_ev = !ext_active && exit_done;

  // ---------------------------------------------------------------
  // reset outputs and start strobes
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      system_clear_out <= 1'b1;
      core_hold        <= 1'b1;
      bus_start        <= 1'b0;
      fetch_start      <= 1'b0;
      reset_vector     <= RESET_VEC;
    end else begin
      // high during any reset, two extra clocks after external release
      system_clear_out <= ext_active || wdt_ev ||
        (state_q == ST_EXT_HOLD) ||
        ((state_q == ST_WDT_HOLD) && !wdt_done) ||
        ((state_q == ST_EXT_EXIT) &&
         (cnt_q < CNT_W'(CLR_HOLD_CYC - 1)));
      core_hold <= ext_active || wdt_ev ||
        (state_q == ST_EXT_HOLD) ||
        ((state_q == ST_WDT_HOLD) && !wdt_done) ||
        ((state_q == ST_EXT_EXIT) &&
         (cnt_q < CNT_W'(BUS_START_CYC - 1)));
      bus_start <= !ext_active && (((state_q == ST_EXT_EXIT) &&
        cnt_at(cnt_q, BUS_START_CYC)) || wdt_done);
      fetch_start  <= fetch_ev || (!ext_active && wdt_done);
      reset_vector <= RESET_VEC;
    end
  end

  // ---------------------------------------------------------------
  // watchdog cause flag and strap latch
  // ---------------------------------------------------------------
  logic wdt_cause_q;
  logic usb_mode_q;
  logic boot_q;
  logic cause_clr;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      wdt_cause_q <= 1'b0;
    end else if (ext_active) begin
      wdt_cause_q <= 1'b0;
    end else if (wdt_ev) begin
      wdt_cause_q <= 1'b1;
    end else if (cause_clr) begin
      wdt_cause_q <= 1'b0;
    end
  end

  // straps are caught once per reset exit, so a pin toggling later
  // cannot remap the usb pins underneath live traffic
  always_ff @(posedge clock) begin
    if (!resetn) begin
      boot_q     <= 1'b1;
      usb_mode_q <= 1'b0;
    end else begin
      boot_q <= 1'b0;
      if (boot_q || (!ext_active &&
          (state_q == ST_EXT_HOLD || wdt_done))) begin
        usb_mode_q <= !usb_phy_strap;
      end
    end
  end

  // ---------------------------------------------------------------
  // usb phy pin mapping
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      usb_tx_plus_out            <= 1'b0;
      usb_tx_minus_out           <= 1'b0;
      usb_phy_output_enable      <= 1'b0;
      usb_tx_plus_oe_n           <= 1'b1;
      usb_tx_minus_oe_n          <= 1'b1;
      usb_phy_output_enable_oe_n <= 1'b1;
      usb_receive_core           <= 1'b0;
    end else begin
      usb_tx_plus_out            <= usb_mode_q && usb_tx_plus_core;
      usb_tx_minus_out           <= usb_mode_q && usb_tx_minus_core;
      usb_phy_output_enable      <= usb_mode_q && usb_phy_oe_core;
      usb_tx_plus_oe_n           <= !usb_mode_q;
      usb_tx_minus_oe_n          <= !usb_mode_q;
      usb_phy_output_enable_oe_n <= !usb_mode_q;
      usb_receive_core           <= usb_mode_q && usb_phy_receive_in;
    end
  end

  // ---------------------------------------------------------------
  // registers and interrupt
  // ---------------------------------------------------------------
  logic [1:0]      clksel_q;
  logic [EV_W-1:0] stat_q;
  logic [EV_W-1:0] ien_q;
  logic [EV_W-1:0] ev_set;
  logic [7:0]      aw_addr_q;
  logic [31:0]     w_data_q;
  logic [3:0]      w_strb_q;
  logic            aw_have_q;
  logic            w_have_q;
  logic            wr_go;

  assign ev_set = {fetch_ev, wdt_ev, ext_ev};
  assign wr_go  = aw_have_q && w_have_q && !s_axi_bvalid;

  function automatic logic wr_hit(input logic [7:0] a,
                                  input logic [7:0] o);
    wr_hit = (a == o);
  endfunction : wr_hit

  assign cause_clr = wr_go && wr_hit(aw_addr_q, ADDR_WDCTL) &&
                     w_strb_q[0] && w_data_q[BIT_WDT_CAUSE];

  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q     <= s_axi_awaddr;
        aw_have_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        w_have_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_hit(aw_addr_q, ADDR_WDCTL) ||
                         wr_hit(aw_addr_q, ADDR_CLKSEL) ||
                         wr_hit(aw_addr_q, ADDR_CLR) ||
                         wr_hit(aw_addr_q, ADDR_IEN)) ?
                        RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      clksel_q <= CLKSEL_RST;
      ien_q    <= IEN_RST;
    end else if (wr_go && w_strb_q[0]) begin
      if (wr_hit(aw_addr_q, ADDR_CLKSEL)) clksel_q <= w_data_q[1:0];
      if (wr_hit(aw_addr_q, ADDR_IEN))    ien_q <= w_data_q[EV_W-1:0];
    end
  end

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge clock) begin
    if (!resetn) begin
      stat_q <= '0;
    end else if (wr_go && w_strb_q[0] && wr_hit(aw_addr_q, ADDR_CLR)) begin
      stat_q <= (stat_q & ~w_data_q[EV_W-1:0]) | ev_set;
    end else begin
      stat_q <= stat_q | ev_set;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      irq                <= 1'b0;
      uart_alt_src_sel   <= 1'b0;
      hsuart_alt_src_sel <= 1'b0;
    end else begin
      irq                <= |(stat_q & ien_q);
      uart_alt_src_sel   <= clksel_q[BIT_UART_SEL];
      hsuart_alt_src_sel <= clksel_q[BIT_HSU_SEL];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      unique case (s_axi_araddr)
        ADDR_WDCTL:  s_axi_rdata <= {30'h0, usb_mode_q, wdt_cause_q};
        ADDR_CLKSEL: s_axi_rdata <= {30'h0, clksel_q};
        ADDR_STAT:   s_axi_rdata <= {29'h0, stat_q};
        ADDR_CLR:    s_axi_rdata <= 32'h0000_0000;
        ADDR_IEN:    s_axi_rdata <= {29'h0, ien_q};
        ADDR_STATE:  s_axi_rdata <= {28'h0, state_q};
        default:     s_axi_rresp <= RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : rsc_top

// file: test/rsc_ext_model.sv
// partner: board reset source and one downstream peripheral
// assumes clear requests come as levels from the bench
`timescale 1ns/1ns
module rsc_ext_model (
  input  wire logic clock,
  input  wire logic clear_req,
  input  wire logic system_clear_out,
  output logic      external_clear_n,
  output int        periph_resets
);
  logic seen_q;
  initial begin
    external_clear_n = 1'b1;
    periph_resets    = 0;
    seen_q           = 1'b0;
  end
  // peripheral counts each reset it receives
  always @(posedge clock) begin
    external_clear_n <= !clear_req;
    // unknown before the first reset edge counts as low
    seen_q           <= (system_clear_out === 1'b1);
    if (system_clear_out === 1'b1 && !seen_q) begin
      periph_resets <= periph_resets + 1;
    end
  end
endmodule : rsc_ext_model

// file: test/rsc_props.sv
// checker: reset exit timing, watchdog hold, usb pin mapping
// assumes rsc_top ports; pins change just after clock edges
`timescale 1ns/1ns
module rsc_props #(
  parameter int WDT_CYCLES = 16
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic external_clear_n,
  input wire logic watchdog_timeout,
  input wire logic system_clear_out,
  input wire logic core_hold,
  input wire logic bus_start,
  input wire logic fetch_start,
  input wire logic usb_tx_plus_core,
  input wire logic usb_tx_plus_out,
  input wire logic usb_tx_plus_oe_n
);
  logic        wd_q;
  logic [16:0] hold_cnt_q;
  // ----------
  // helpers
  // ----------
  // external clear cancels a watchdog origin
  always_ff @(posedge clock) begin
    if (!resetn || !external_clear_n) begin
      wd_q <= 1'b0;
    end else if (watchdog_timeout && !core_hold) begin
      wd_q <= 1'b1;
    end
  end
  always_ff @(posedge clock) begin
    if (!resetn || !core_hold) begin
      hold_cnt_q <= 17'h0;
    end else begin
      hold_cnt_q <= hold_cnt_q + 17'h1;
    end
  end
  // ----------
  // properties
  // ----------
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  a_ext_assert: assert property (
    $fell(external_clear_n) |-> ##3 system_clear_out)
    else $error("system clear late after external clear");
  a_clear_two: assert property (
    $rose(external_clear_n) |-> system_clear_out[*5] ##1 !system_clear_out)
    else $error("system clear hold wrong");
  a_bus_start: assert property (
    $rose(external_clear_n) |-> !bus_start[*8] ##1 bus_start ##1 !bus_start)
    else $error("first bus cycle mistimed");
  a_fetch_time: assert property (
    $rose(external_clear_n) |-> ##10 fetch_start)
    else $error("fetch start mistimed");
  a_core_hold: assert property (
    $rose(external_clear_n) |-> core_hold[*8] ##1 !core_hold)
    else $error("core hold release mistimed");
  a_wdt_enter: assert property (
    watchdog_timeout && !core_hold && external_clear_n
      |=> system_clear_out && core_hold)
    else $error("watchdog reset not entered");
  a_wdt_hold: assert property (
    $fell(core_hold) && wd_q
      |-> hold_cnt_q == WDT_CYCLES && bus_start && fetch_start)
    else $error("watchdog hold length wrong");
  a_usb_follow: assert property (
    !usb_tx_plus_oe_n && !$past(usb_tx_plus_oe_n)
      |-> usb_tx_plus_out == $past(usb_tx_plus_core))
    else $error("usb plus pin not following core");
  a_strap_hold: assert property (
    !core_hold && !$past(core_hold) && !$past(core_hold, 2)
      |-> $stable(usb_tx_plus_oe_n))
    else $error("usb mapping changed outside reset");
endmodule : rsc_props
bind rsc_top rsc_props #(.WDT_CYCLES(WDT_CYCLES)) i_rsc_props (.*);

// file: test/tb_reset_sequencing_control.sv
// testbench: register rows, external and watchdog resets, usb strap
// assumes rsc_top with the watchdog hold shortened to 16 clocks
`timescale 1ns/1ns
module tb_reset_sequencing_control;
  import rsc_pkg::*;
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] data;
    logic [1:0]  resp;
    logic [1:0]  sel;
  } rsc_row_t;
  logic        clock, resetn, clear_req, watchdog_timeout, usb_phy_strap;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, external_clear_n, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        usb_tx_plus_core, usb_tx_minus_core, usb_phy_oe_core;
  logic        usb_phy_receive_in, system_clear_out, core_hold, bus_start;
  logic        fetch_start, uart_alt_src_sel, hsuart_alt_src_sel;
  logic        usb_tx_plus_out, usb_tx_plus_oe_n, usb_tx_minus_out;
  logic        usb_tx_minus_oe_n, usb_phy_output_enable, usb_receive_core;
  logic        usb_phy_output_enable_oe_n;
  logic [19:0] reset_vector;
  int          periph_resets, cycles, miscompares, comparisons;
  rsc_row_t rows [13] = '{
    '{1'b0, ADDR_CLKSEL, 32'h0, RESP_OKAY, 2'h0},
    '{1'b0, ADDR_IEN, 32'h0, RESP_OKAY, 2'h0},
    '{1'b1, ADDR_CLKSEL, 32'h1, RESP_OKAY, 2'h1},
    '{1'b0, ADDR_CLKSEL, 32'h1, RESP_OKAY, 2'h1},
    '{1'b1, ADDR_CLKSEL, 32'h2, RESP_OKAY, 2'h2},
    '{1'b0, ADDR_CLKSEL, 32'h2, RESP_OKAY, 2'h2},
    '{1'b1, ADDR_CLKSEL, 32'h3, RESP_OKAY, 2'h3},
    '{1'b0, ADDR_CLKSEL, 32'h3, RESP_OKAY, 2'h3},
    '{1'b1, 8'h18, 32'h5, RESP_SLVERR, 2'h3},
    '{1'b0, 8'h18, 32'h0, RESP_SLVERR, 2'h3},
    '{1'b0, ADDR_CLR, 32'h0, RESP_OKAY, 2'h3},
    '{1'b0, ADDR_STATE, 32'h1, RESP_OKAY, 2'h3},
    '{1'b1, ADDR_CLKSEL, 32'h0, RESP_OKAY, 2'h0}};

  rsc_top #(.WDT_CYCLES(16)) i_rsc_top (.*);
  rsc_ext_model i_rsc_ext_model (.*);

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // hang guard, runs need a few hundred clocks
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      report_and_stop();
    end
  end
  // ----------
  // tasks
  // ----------
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clock);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clock);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clock);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clock);
  endtask : axi_rd
  task automatic pulse_clear;
    clear_req <= 1'b1;
    repeat (10) @(posedge clock);
    clear_req <= 1'b0;
    wait (fetch_start === 1'b1);
    @(posedge clock);
  endtask : pulse_clear
  task automatic pulse_wdt;
    watchdog_timeout <= 1'b1;
    @(posedge clock);
    watchdog_timeout <= 1'b0;
  endtask : pulse_wdt
  task automatic report_and_stop;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop
  // ----------
  // sequence
  // ----------
  initial begin
    {resetn, clear_req, watchdog_timeout, s_axi_awvalid} = 4'h0;
    {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    usb_phy_strap = 1'b1;
    {usb_tx_plus_core, usb_tx_minus_core} = 2'h2;
    {usb_phy_oe_core, usb_phy_receive_in} = 2'h3;
    repeat (4) @(posedge clock);
    check("clear_in_reset", system_clear_out, 32'h1);
    resetn <= 1'b1;
    wait (fetch_start === 1'b1);
    @(posedge clock);
    check("vector", reset_vector, RESET_VEC);
    check("pins_off", {usb_tx_plus_oe_n, usb_tx_minus_oe_n,
          usb_phy_output_enable_oe_n}, 32'h7);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        axi_wr(rows[i].addr, rows[i].data);
      end else begin
        axi_rd(rows[i].addr);
        check("rdata", rd, rows[i].data);
      end
      check("resp", resp, rows[i].resp);
      check("src_sel", {hsuart_alt_src_sel, uart_alt_src_sel},
            rows[i].sel);
    end
    // a write with byte lane 0 off must leave the selects alone
    s_axi_wstrb <= 4'h0;
    axi_wr(ADDR_CLKSEL, 32'h3);
    s_axi_wstrb <= 4'hF;
    axi_rd(ADDR_CLKSEL);
    check("strb_ignored", rd, 32'h0);
    axi_wr(ADDR_CLR, 32'h7);
    // strap moves in run: mapping must wait for a reset
    usb_phy_strap <= 1'b0;
    repeat (3) @(posedge clock);
    check("strap_held", usb_tx_plus_oe_n, 32'h1);
    pulse_clear();
    check("pins_on", {usb_tx_plus_oe_n, usb_tx_minus_oe_n,
          usb_phy_output_enable_oe_n}, 32'h0);
    check("pin_vals", {usb_tx_plus_out, usb_tx_minus_out,
          usb_phy_output_enable, usb_receive_core}, 32'hB);
    usb_tx_plus_core <= 1'b0;
    repeat (2) @(posedge clock);
    check("plus_follow", usb_tx_plus_out, 32'h0);
    axi_rd(ADDR_STAT);
    check("stat_ext", rd, 32'h5);
    check("irq_masked", irq, 32'h0);
    axi_wr(ADDR_IEN, 32'h1);
    check("irq_on", irq, 32'h1);
    axi_wr(ADDR_CLR, 32'h1);
    check("irq_cleared", irq, 32'h0);
    axi_wr(ADDR_IEN, 32'h0);
    axi_wr(ADDR_CLR, 32'h7);
    pulse_wdt();
    wait (core_hold === 1'b1);
    wait (core_hold === 1'b0);
    @(posedge clock);
    axi_rd(ADDR_WDCTL);
    check("wdt_flag", rd, 32'h3);
    axi_rd(ADDR_STAT);
    check("stat_wdt", rd, 32'h2);
    axi_wr(ADDR_WDCTL, 32'h1);
    axi_wr(ADDR_CLR, 32'h7);
    pulse_wdt();
    repeat (4) @(posedge clock);
    pulse_clear();
    axi_rd(ADDR_WDCTL);
    check("flag_overridden", rd, 32'h2);
    axi_rd(ADDR_STAT);
    check("stat_override", rd, 32'h7);
    axi_rd(ADDR_STATE);
    check("state_run", rd, 32'h1);
    check("periph_resets", periph_resets, 32'h4);
    report_and_stop();
  end
endmodule : tb_reset_sequencing_control
